// *** dma_ack_pkg.sv ***
// Shared constants, types and register map of the DMA acknowledge adapter.
// Notes on behaviour
// RULE1 - Handshake host answers each request with acknowledge plus read or write.
// RULE2 - Request-only host accesses the generator port with address, select, command.
// RULE3 - Generator port access makes the block drive the chip acknowledge itself.
// RULE4 - Small-drive DMA mode stretches generated acknowledge to 510 ns using wait.
// RULE5 - Acknowledge source selectable: host line or generator; generator is default.
// RULE6 - Host acknowledge forwarded directly or, by default, gated by read/write strobe.
// RULE7 - Unqualified host acknowledge must stay true 510 ns and be glitch free.
// RULE8 - Host ignoring wait must hold read and write commands for 510 ns.
// RULE9 - Host waits while wait is low; option disconnects wait, enabled by default.
// RULE10 - Terminate output derives from controller interrupt to end DMA transfers.
// RULE11 - Host heeds terminate only during DMA transfers.
// RULE12 - Mask gates terminate: always on, off, latch-driven or option-line-driven.
// RULE13 - Mask source latch0, latch1, option0, option1, always or off; latch1 default.
// RULE14 - Mask set to disabled holds terminate inactive whatever the interrupt.
package dma_ack_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the AHB-Lite bus.
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] ISTAT_OFF = 8'h08;
    localparam logic [7:0] IMASK_OFF = 8'h0C;

    // ------------------------------------------------------------------
    // Timing of the stretched acknowledge.
    // ------------------------------------------------------------------
    localparam int ACK_MIN_NS = 510;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int ACK_CYC_INT = (ACK_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] ACK_CYC = CNT_W'(ACK_CYC_INT);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // ------------------------------------------------------------------
    // Terminate mask sources and control word.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MASK_ALWAYS,
        MASK_LATCH0,
        MASK_LATCH1,
        MASK_OPT0,
        MASK_OPT1,
        MASK_OFF
    } mask_sel_t;

    typedef struct packed {
        logic ack_from_host;
        logic qualify_ack;
        logic wait_enable;
        logic drive_525;
        logic dma_mode;
        mask_sel_t mask_sel;
        logic latch0;
        logic latch1;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);
    localparam ctrl_t CTRL_RST = '{
        ack_from_host: 1'b0,
        qualify_ack: 1'b1,
        wait_enable: 1'b1,
        drive_525: 1'b1,
        dma_mode: 1'b0,
        mask_sel: MASK_LATCH1,
        latch0: 1'b0,
        latch1: 1'b0
    };

    // ------------------------------------------------------------------
    // Interrupt status bits and pin group.
    // ------------------------------------------------------------------
    localparam int INT_W = 2;
    localparam int INT_ACK_DONE = 0;
    localparam int INT_TERM = 1;
    localparam int STAT_W = 4;

    typedef struct packed {
        logic host_dma_ack;
        logic io_read_strobe;
        logic io_write_strobe;
        logic gen_port_sel;
        logic option0;
        logic option1;
        logic fdc_int;
    } pins_t;

endpackage

// *** pin_sync.sv ***
// Two-stage synchroniser for the asynchronous pin group.
`timescale 1ns/1ps
module pin_sync
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire dma_ack_pkg::pins_t pins_raw,
    output dma_ack_pkg::pins_t pins_sync
);
    import dma_ack_pkg::*;

    localparam int PW = $bits(pins_t);

    typedef struct packed {
        logic [PW-1:0] meta;
        logic [PW-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // -------------------------------------------------------------
    // Per-bit stages; the first stage feeds only the second.
    // -------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PW; i++)
        begin : g_bit
            always_comb
            begin
                s_d.meta[i] = pins_raw[i];
                s_d.stable[i] = s_q.meta[i];
            end
        end
    endgenerate

    // Registers the two stages.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pins_sync = pins_t'(s_q.stable);
endmodule

// *** ack_pulse_gen.sv ***
// On-board acknowledge generator with minimum pulse stretching.
`timescale 1ns/1ps
module ack_pulse_gen
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic access,
    input wire logic stretch,
    output logic ack,
    output logic wait_req,
    output logic done
);
    import dma_ack_pkg::*;

    typedef struct packed {
        logic active;
        logic [CNT_W-1:0] cnt;
        logic done;
    } gen_state_t;

    gen_state_t s_q;
    gen_state_t s_d;

    // -------------------------------------------------------------
    // Pulse control.
    // -------------------------------------------------------------
    // The pulse starts on a port access and ends once the access is
    // gone; when stretching, not before the minimum count has run.
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.active)
        begin
            if (access)
            begin
                s_d.active = 1'b1; // RULE3
                s_d.cnt = ACK_CYC - CNT_ONE;
            end
        end
        else
        begin
            if (s_q.cnt != CNT_ZERO)
            begin
                s_d.cnt = s_q.cnt - CNT_ONE;
            end
            if (!access && (!stretch || s_q.cnt == CNT_ZERO))
            begin
                s_d.active = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // Registers the generator state.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // When stretching, wait is held while the minimum width has not yet elapsed.
    assign ack = s_q.active;
    assign wait_req = s_q.active && stretch && (s_q.cnt != CNT_ZERO); // RULE4
    assign done = s_q.done;
endmodule

// *** dma_ack_wait_terminate.sv ***
// Top of the DMA acknowledge, wait and terminate adapter with AHB-Lite regs.
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dma_ack_wait_terminate
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire dma_ack_pkg::pins_t pins_raw,
    output logic fdc_dma_ack,
    output logic bus_wait_n,
    output logic bus_wait_oe_n,
    output logic dma_terminate,
    output logic bus_interrupt_1,
    output logic irq
);
    import dma_ack_pkg::*;

    // ------------------------------------------------------------------
    // State of the block.
    // ------------------------------------------------------------------
    typedef struct packed {
        ctrl_t ctrl;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic fdc_ack;
        logic wait_n;
        logic wait_oe_n;
        logic term;
        logic bus_int;
        logic irq;
    } top_state_t;

    localparam top_state_t TOP_RST = '{
        ctrl: CTRL_RST,
        int_stat: '0,
        int_mask: '0,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h00000000,
        fdc_ack: 1'b0,
        wait_n: 1'b1,
        wait_oe_n: 1'b1,
        term: 1'b0,
        bus_int: 1'b0,
        irq: 1'b0
    };

    top_state_t s_q;
    top_state_t s_d;

    pins_t pins;
    logic gen_ack;
    logic gen_wait;
    logic gen_done;
    logic strobe;
    logic gen_access;
    logic stretch;

    // ------------------------------------------------------------------
    // Pin synchronisation and acknowledge generator.
    // ------------------------------------------------------------------
    pin_sync u_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins_raw(pins_raw),
        .pins_sync(pins)
    );

    // Either command strobe marks a bus cycle in progress.
    assign strobe = pins.io_read_strobe | pins.io_write_strobe;

    // The generator only runs when it is the selected source, so a
    // stray select during host-acknowledge mode raises no wait.
    assign gen_access = pins.gen_port_sel && strobe
                        && !s_q.ctrl.ack_from_host; // RULE3
    assign stretch = s_q.ctrl.dma_mode && s_q.ctrl.drive_525; // RULE4

    ack_pulse_gen u_gen
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .access(gen_access),
        .stretch(stretch),
        .ack(gen_ack),
        .wait_req(gen_wait),
        .done(gen_done)
    );

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // One process covers the signal path, the event flags and the bus
    // slave, so that a read issued right after a write sees the new value.
    always_comb
    begin
        logic host_path;
        logic mask_en;
        logic acc;
        logic [INT_W-1:0] ev;
        logic [7:0] raddr;
        s_d = s_q;
        host_path = 1'b0;
        mask_en = 1'b0;
        acc = 1'b0;
        ev = '0;
        raddr = haddr[7:0];

        // Host acknowledge is gated by a command strobe unless the
        // host guarantees a clean, long enough acknowledge itself.
        if (s_q.ctrl.qualify_ack)
        begin
            host_path = pins.host_dma_ack && strobe; // RULE6
        end
        else
        begin
            host_path = pins.host_dma_ack; // RULE6 RULE7
        end

        // Source selection for the chip acknowledge.
        if (s_q.ctrl.ack_from_host)
        begin
            s_d.fdc_ack = host_path; // RULE5 RULE1
        end
        else
        begin
            s_d.fdc_ack = gen_ack; // RULE5 RULE2
        end

        // Wait is active low; when disconnected the pin is released and
        // idles high so a floating line never looks like a wait.
        s_d.wait_oe_n = !s_q.ctrl.wait_enable; // RULE9
        s_d.wait_n = !(gen_wait && s_q.ctrl.wait_enable); // RULE9 RULE4

        // Terminate mask source; unknown codes fall back to disabled.
        case (s_q.ctrl.mask_sel)
            MASK_ALWAYS: mask_en = 1'b1; // RULE13
            MASK_LATCH0: mask_en = s_q.ctrl.latch0; // RULE12
            MASK_LATCH1: mask_en = s_q.ctrl.latch1; // RULE13
            MASK_OPT0: mask_en = pins.option0; // RULE12
            MASK_OPT1: mask_en = pins.option1; // RULE12
            MASK_OFF: mask_en = 1'b0; // RULE14
            default: mask_en = 1'b0;
        endcase

        // Terminate follows the chip interrupt, so it can also move on
        // events such as ready changes; the host must filter those.
        s_d.bus_int = pins.fdc_int;
        s_d.term = pins.fdc_int && mask_en; // RULE10 RULE11

        // Events for the sticky status bits.
        ev[INT_ACK_DONE] = gen_done;
        ev[INT_TERM] = s_d.term && !s_q.term;

        // Data phase of a write accepted in the previous cycle.
        if (s_q.wr_pend)
        begin
            case (s_q.wr_addr)
                CTRL_OFF: s_d.ctrl = ctrl_t'(hwdata[CTRL_W-1:0]);
                ISTAT_OFF: s_d.int_stat = s_q.int_stat & ~hwdata[INT_W-1:0];
                IMASK_OFF: s_d.int_mask = hwdata[INT_W-1:0];
                default: s_d.wr_pend = 1'b0;
            endcase
        end

        // Setting after clearing lets a same-cycle event win.
        s_d.int_stat = s_d.int_stat | ev;
        s_d.irq = |(s_d.int_stat & s_d.int_mask);

        // Address phase: latch writes, prepare read data at once.
        acc = hsel && htrans[1] && hready;
        s_d.wr_pend = acc && hwrite;
        s_d.wr_addr = haddr[7:0];
        if (acc && !hwrite)
        begin
            case (raddr)
                CTRL_OFF:
                    s_d.rdata = {{(32-CTRL_W){1'b0}}, s_d.ctrl};
                STAT_OFF:
                    s_d.rdata = {{(32-STAT_W){1'b0}}, s_q.fdc_ack,
                                 !s_q.wait_n, s_q.term, s_q.bus_int};
                ISTAT_OFF:
                    s_d.rdata = {{(32-INT_W){1'b0}}, s_d.int_stat};
                IMASK_OFF:
                    s_d.rdata = {{(32-INT_W){1'b0}}, s_d.int_mask};
                default:
                    s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= TOP_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    // The slave never stalls and never errors; hsize is not checked
    // because only whole-word transfers are expected.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign fdc_dma_ack = s_q.fdc_ack;
    assign bus_wait_n = s_q.wait_n;
    assign bus_wait_oe_n = s_q.wait_oe_n;
    assign dma_terminate = s_q.term;
    assign bus_interrupt_1 = s_q.bus_int;
    assign irq = s_q.irq;
endmodule

// *** dma_ack_wait_terminate_assertions.sv ***
// Port-level concurrent checks for the DMA acknowledge adapter.
`timescale 1ns/1ps
module dma_ack_wait_terminate_assertions
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire dma_ack_pkg::pins_t pins_raw,
    input wire logic fdc_dma_ack,
    input wire logic bus_wait_n,
    input wire logic bus_wait_oe_n,
    input wire logic dma_terminate,
    input wire logic bus_interrupt_1,
    input wire logic irq
);
    import dma_ack_pkg::*;
    logic [5:0] low_q;
    logic [1:0] up_q;

    // Counts wait-low cycles, and edges since reset so that the pin
    // pipeline is full before its delay is compared.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            low_q <= 6'h00;
            up_q <= 2'h0;
        end
        else
        begin
            low_q <= bus_wait_n ? 6'h00 : low_q + 6'h01;
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_WAIT_OFF: assert property (bus_wait_oe_n |-> bus_wait_n)
        else $error("wait asserted while disconnected");
    AST_WAIT_START: assert property ($fell(bus_wait_n) |->
        $rose(fdc_dma_ack) && !bus_wait_oe_n)
        else $error("wait fell without a new acknowledge");
    AST_WAIT_LEN: assert property ($rose(bus_wait_n) |-> low_q == 6'h14)
        else $error("wait low for the wrong number of cycles");
    AST_WAIT_MAX: assert property (low_q <= 6'h14)
        else $error("wait held low too long");
    AST_ACK_HELD: assert property ((!bus_wait_n || $rose(bus_wait_n)) |->
        fdc_dma_ack)
        else $error("acknowledge dropped while stretched");
    AST_ACK_CAUSE: assert property ($rose(fdc_dma_ack) |->
        $past(pins_raw.host_dma_ack, 3) || $past(pins_raw.gen_port_sel, 4))
        else $error("acknowledge rose with no source");
    AST_INT_FOLLOW: assert property (up_q == 2'h3 |->
        bus_interrupt_1 == $past(pins_raw.fdc_int, 3))
        else $error("interrupt line does not follow controller");
    AST_TERM_GATED: assert property (dma_terminate |->
        bus_interrupt_1)
        else $error("terminate active without interrupt");
endmodule

bind dma_ack_wait_terminate dma_ack_wait_terminate_assertions chk (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .pins_raw, .fdc_dma_ack,
    .bus_wait_n, .bus_wait_oe_n, .dma_terminate, .bus_interrupt_1, .irq);

// *** host_dma_model.sv ***
// Behavioural host DMA controller that drives the host-side pins.
`timescale 1ns/1ps
module host_dma_model
(
    input wire logic ref_clk,
    input wire logic bus_wait_n,
    output logic host_dma_ack,
    output logic io_read_strobe,
    output logic io_write_strobe,
    output logic gen_port_sel
);
    // Counts transfers whose wait never ended; the bench reads it.
    int stalls = 0;

    // Idle host: no acknowledge, no command. Terminate is never watched
    // here, since it means nothing outside a transfer.
    initial
    begin
        host_dma_ack = 1'b0;
        io_read_strobe = 1'b0;
        io_write_strobe = 1'b0;
        gen_port_sel = 1'b0;
    end

    // One transfer; the host takes wait states while wait is low.
    task automatic transfer(input logic use_gen, input logic [1:0] cmd,
        input int hold);
        int n;
        @(posedge ref_clk);
        gen_port_sel <= use_gen;
        host_dma_ack <= !use_gen;
        io_read_strobe <= cmd[1];
        io_write_strobe <= cmd[0];
        repeat (hold) @(posedge ref_clk);
        n = 0;
        while (bus_wait_n !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (bus_wait_n !== 1'b1)
            stalls++;
        gen_port_sel <= 1'b0;
        host_dma_ack <= 1'b0;
        io_read_strobe <= 1'b0;
        io_write_strobe <= 1'b0;
    endtask
endmodule

// *** dma_ack_wait_terminate_tb.sv ***
// Self-checking bench for the DMA acknowledge, wait and terminate adapter.
`timescale 1ns/1ps
module dma_ack_wait_terminate_tb;
    import dma_ack_pkg::*;
    localparam int ACK_CYCLES = (510 + 24) / 25;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic opt0 = 1'b0;
    logic opt1 = 1'b0;
    logic fint = 1'b0;
    logic hready, hresp, fdc_dma_ack, bus_wait_n, bus_wait_oe_n;
    logic dma_terminate, bus_interrupt_1, irq, h_ack, rd_s, wr_s, sel;
    logic [31:0] hrdata;
    logic [31:0] rd;
    pins_t pins;
    ctrl_t c;
    int failures = 0;
    int num_checks = 0;
    int ack_w, wait_w, h, e;

    assign pins = {h_ack, rd_s, wr_s, sel, opt0, opt1, fint};

    // Free-running bus clock.
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    dma_ack_wait_terminate dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .pins_raw(pins),
        .fdc_dma_ack(fdc_dma_ack), .bus_wait_n(bus_wait_n),
        .bus_wait_oe_n(bus_wait_oe_n), .dma_terminate(dma_terminate),
        .bus_interrupt_1(bus_interrupt_1), .irq(irq));
    host_dma_model host (.ref_clk(ref_clk), .bus_wait_n(bus_wait_n),
        .host_dma_ack(h_ack), .io_read_strobe(rd_s),
        .io_write_strobe(wr_s), .gen_port_sel(sel));

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        repeat (2)
        begin
            k = 0;
            do
            begin
                @(posedge ref_clk);
                k++;
            end
            while (hready !== 1'b1 && k < 16);
            if (hready !== 1'b1)
            begin
                failures++;
                $display("mismatch at %0t: bus wait limit", $time);
                close_out();
            end
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
        end
        rd = hrdata;
    endtask

    // Runs one host transfer and counts acknowledge and wait cycles.
    task automatic run(input logic g, input logic [1:0] cmd, input int n);
        ack_w = 0;
        wait_w = 0;
        fork
            host.transfer(g, cmd, n);
            repeat (70)
            begin
                @(posedge ref_clk);
                if (fdc_dma_ack === 1'b1)
                    ack_w++;
                if (bus_wait_n === 1'b0)
                    wait_w++;
            end
        join
        if (host.stalls != 0)
        begin
            failures++;
            $display("mismatch at %0t: host wait limit", $time);
            close_out();
        end
    endtask

    // Reference model of the terminate mask; codes 6 and 7 act as off.
    function automatic logic term_exp(int code, ctrl_t m);
        case (code)
            0: return 1'b1;
            1: return m.latch0;
            2: return m.latch1;
            3: return opt0;
            4: return opt1;
            default: return 1'b0;
        endcase
    endfunction

    initial
    begin
        void'($urandom(32'h152d3638));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check(bus_wait_oe_n, 1'b0);
        check({fdc_dma_ack, bus_wait_n, dma_terminate, irq}, 4'h4);
        check(hresp, 1'b0);
        ahb(1'b0, CTRL_OFF, 32'h0);
        check(rd, 32'(CTRL_RST));
        ahb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, IMASK_OFF, 32'h0);
        // Generated acknowledge, stretched, then its interrupt.
        c = CTRL_RST;
        c.dma_mode = 1'b1;
        ahb(1'b1, CTRL_OFF, 32'(c));
        run(1'b1, 2'h2, 5 + $urandom_range(3));
        check(ack_w >= ACK_CYCLES, 1'b1);
        check(wait_w, ACK_CYCLES - 1);
        ahb(1'b0, ISTAT_OFF, 32'h0);
        check({rd[INT_ACK_DONE], irq}, 2'h2);
        ahb(1'b1, IMASK_OFF, 32'h3);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b1);
        ahb(1'b1, ISTAT_OFF, 32'h3);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b0);
        // Large drives: no stretching, no wait.
        c.drive_525 = 1'b0;
        ahb(1'b1, CTRL_OFF, 32'(c));
        run(1'b1, 2'h1, 6);
        check(ack_w > 0, 1'b1);
        check(wait_w, 0);
        // Wait disconnected.
        c.drive_525 = 1'b1;
        c.wait_enable = 1'b0;
        ahb(1'b1, CTRL_OFF, 32'(c));
        run(1'b1, 2'h2, 6);
        check(bus_wait_oe_n, 1'b1);
        check(wait_w, 0);
        ahb(1'b1, ISTAT_OFF, 32'h3);
        // Host acknowledge, direct and qualified; generator refused.
        c = CTRL_RST;
        c.ack_from_host = 1'b1;
        for (int q = 0; q < 2; q++)
        begin
            c.qualify_ack = q[0];
            ahb(1'b1, CTRL_OFF, 32'(c));
            for (int m = 0; m < 3; m++)
            begin
                h = 3 + $urandom_range(7);
                run(1'b0, 2'(m), h);
                check(ack_w, (q == 1 && m == 0) ? 0 : h);
            end
        end
        run(1'b1, 2'h2, 6);
        check(ack_w, 0);
        // Every terminate mask source.
        c = CTRL_RST;
        for (int code = 0; code < 8; code++)
        begin
            c.mask_sel = mask_sel_t'(code[2:0]);
            c.latch0 = 1'($urandom_range(1));
            c.latch1 = 1'($urandom_range(1));
            opt0 <= 1'($urandom_range(1));
            opt1 <= 1'($urandom_range(1));
            ahb(1'b1, CTRL_OFF, 32'(c));
            fint <= 1'b1;
            repeat (6) @(posedge ref_clk);
            e = term_exp(code, c);
            check({dma_terminate, bus_interrupt_1}, {e[0], 1'b1});
            ahb(1'b0, ISTAT_OFF, 32'h0);
            check({rd[INT_TERM], irq}, {e[0], e[0]});
            ahb(1'b1, ISTAT_OFF, 32'h3);
            fint <= 1'b0;
            repeat (6) @(posedge ref_clk);
            check({dma_terminate, bus_interrupt_1}, 2'h0);
        end
        close_out();
    end
endmodule
